// File: hw/lib_bridge.sv
// Host to expansion-bus bridge: register port, sequencer, pin sync and interrupt gating
// Contract
// R1 - Bridge is sole bus master, no request
// R2 - No refresh cycles; refresh held high
// R3 - No DMA; acknowledges high, requests ignored
// R4 - Terminal count held low always
// R5 - Wide cycle only when module signals width
// R6 - Skip addresses claimed on host side; code applies the claim to I/O requests only, memory requests ignore it
// R7 - Block on-board logic range C80-CCF
// R8 - Block 2E/2F and C00-C7F always
// R9 - Enabled serial port blocks its 8 bytes
// R10 - Serial bases from fixed list, disable frees
// R11 - Memory forwarded only A0000-B7FFF
// R12 - Only lines 3-7, 9-12, 15 routed
// R13 - Per-line enable, cleared at reset
// R14 - Lines not shared, no combining
// R15 - One bus cycle per forwarded request
`timescale 1ns/100ps
`default_nettype none
`include "lib_defines.svh"
module lib_bridge (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        req_i,
  input  wire logic        req_mem_i,
  input  wire logic        req_write_i,
  input  wire logic        req_wide_i,
  input  wire logic [19:0] req_addr_i,
  input  wire logic [15:0] req_wdata_i,
  input  wire logic        host_claim_i,
  output logic             ack_o,
  output logic             ack_fwd_o,
  output logic      [15:0] rdata_o,
  output logic             busy_o,
  output logic      [19:0] isa_sa_o,
  output logic             isa_ale_o,
  output logic             isa_sbhe_n_o,
  output logic             isa_ior_n_o,
  output logic             isa_iow_n_o,
  output logic             isa_memr_n_o,
  output logic             isa_memw_n_o,
  input  wire logic [15:0] isa_sd_i,
  output logic      [15:0] isa_sd_o,
  output logic             isa_sd_oe_o,
  input  wire logic        isa_iocs16_n_i,
  input  wire logic        isa_iochrdy_i,
  input  wire logic [15:0] isa_irq_i,
  output logic      [15:0] irq_o,
  output logic             isa_refresh_n_o,
  output logic      [6:0]  isa_dack_n_o,
  output logic             isa_tc_o
);
  localparam int SW = 34;

  lib_dec_if dec ();
  lib_decode u_dec (.d(dec.dec));

  lib_pkg::lib_state_e st_q;
  logic [7:0]  cnt_q;
  logic [7:0]  wt_q;
  logic        mem_q;
  logic        write_q;
  logic        wide_q;
  logic        wide_run_q;
  logic        claim_q;
  logic [19:0] addr_q;
  logic [15:0] wdata_q;
  logic [31:0] com_q;
  logic [15:0] irq_en_q;
  logic        blk_q;
  logic        narrow_q;
  logic        blk_set;
  logic        narrow_set;
  logic        sts_wr;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] flt_q;
  logic [15:0] sd_f;
  logic        cs16_n_f;
  logic        rdy_f;
  logic [15:0] irq_f;
  logic        strobe;
  logic        cmd_done;

  assign dec.addr       = addr_q;
  assign dec.is_mem     = mem_q;
  assign dec.host_claim = claim_q;
  assign dec.com_cfg    = com_q;

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      flt_q <= {16'h0000, 1'b1, 1'b1, 16'h0000};
    end else begin
      s1_q  <= {isa_irq_i, isa_iocs16_n_i, isa_iochrdy_i, isa_sd_i};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
    end
  end
  assign sd_f     = flt_q[15:0];
  assign rdy_f    = flt_q[16];
  assign cs16_n_f = flt_q[17];
  assign irq_f    = flt_q[33:18];

  assign strobe   = !isa_ior_n_o || !isa_iow_n_o || !isa_memr_n_o || !isa_memw_n_o;
  assign cmd_done = (st_q == lib_pkg::LIB_ST_CMD) && (cnt_q == 8'h00)
                 && (rdy_f || (wt_q == `LIB_RDY_MAX_CYC));
  assign blk_set    = (st_q == lib_pkg::LIB_ST_DEC) && !dec.fwd;
  assign narrow_set = (st_q == lib_pkg::LIB_ST_ADDR) && (cnt_q == 8'h00) && wide_q && !mem_q && cs16_n_f;
  assign sts_wr     = reg_wr_i && (reg_addr_i == `LIB_REG_STATUS);

  // Unused bus features: the bridge is always master; no refresh, DMA or terminal count
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      isa_refresh_n_o <= 1'b1; // R2
      isa_dack_n_o    <= 7'h7f; // R3
      isa_tc_o        <= 1'b0; // R4
    end else begin
      isa_refresh_n_o <= 1'b1; // R2
      isa_dack_n_o    <= 7'h7f; // R3
      isa_tc_o        <= 1'b0; // R4
    end
  end

  // Sequencer: one bus cycle per forwarded request
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q         <= lib_pkg::LIB_ST_IDLE;
      cnt_q        <= 8'h00;
      wt_q         <= 8'h00;
      mem_q        <= 1'b0;
      write_q      <= 1'b0;
      wide_q       <= 1'b0;
      wide_run_q   <= 1'b0;
      claim_q      <= 1'b0;
      addr_q       <= 20'h00000;
      wdata_q      <= 16'h0000;
      ack_o        <= 1'b0;
      ack_fwd_o    <= 1'b0;
      rdata_o      <= 16'h0000;
      isa_sa_o     <= 20'h00000;
      isa_ale_o    <= 1'b0;
      isa_sbhe_n_o <= 1'b1;
      isa_ior_n_o  <= 1'b1;
      isa_iow_n_o  <= 1'b1;
      isa_memr_n_o <= 1'b1;
      isa_memw_n_o <= 1'b1;
      isa_sd_o     <= 16'h0000;
      isa_sd_oe_o  <= 1'b0;
    end else begin
      ack_o     <= 1'b0;
      isa_ale_o <= 1'b0;
      case (st_q)
        lib_pkg::LIB_ST_IDLE: begin
          // Requests while busy are dropped; host waits for the answer
          if (req_i) begin
            st_q    <= lib_pkg::LIB_ST_DEC;
            mem_q   <= req_mem_i;
            write_q <= req_write_i;
            wide_q  <= req_wide_i;
            addr_q  <= req_addr_i;
            wdata_q <= req_wdata_i;
            claim_q <= host_claim_i;
          end
        end
        lib_pkg::LIB_ST_DEC: begin
          if (dec.fwd) begin
            st_q      <= lib_pkg::LIB_ST_ADDR; // R6 R7 R8 R9 R11
            cnt_q     <= `LIB_ADDR_CYC - 8'h01;
            isa_sa_o  <= addr_q;
            isa_ale_o <= 1'b1;
          end else begin
            st_q      <= lib_pkg::LIB_ST_IDLE;
            ack_o     <= 1'b1;
            ack_fwd_o <= 1'b0;
            rdata_o   <= `LIB_RD_BLOCKED;
          end
        end
        lib_pkg::LIB_ST_ADDR: begin
          if (cnt_q == 8'h00) begin
            st_q  <= lib_pkg::LIB_ST_CMD;
            cnt_q <= `LIB_CMD_CYC - 8'h01;
            wt_q  <= 8'h00;
            // Width decided once the module has had time to answer on its width line
            wide_run_q   <= wide_q && !mem_q && !cs16_n_f; // R5
            isa_sbhe_n_o <= !(wide_q && !mem_q && !cs16_n_f); // R5
            isa_ior_n_o  <= !(!mem_q && !write_q);
            isa_iow_n_o  <= !(!mem_q && write_q);
            isa_memr_n_o <= !(mem_q && !write_q);
            isa_memw_n_o <= !(mem_q && write_q);
            isa_sd_o     <= wdata_q;
            isa_sd_oe_o  <= write_q; // R1
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        lib_pkg::LIB_ST_CMD: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (!rdy_f && (wt_q != `LIB_RDY_MAX_CYC)) begin
            wt_q <= wt_q + 8'h01;
          end
          // A module holding ready low forever is cut off after the longest wait
          if (cmd_done) begin
            st_q         <= lib_pkg::LIB_ST_RECOV; // R15
            cnt_q        <= `LIB_RECOV_CYC - 8'h01;
            isa_ior_n_o  <= 1'b1;
            isa_iow_n_o  <= 1'b1;
            isa_memr_n_o <= 1'b1;
            isa_memw_n_o <= 1'b1;
            isa_sbhe_n_o <= 1'b1;
            isa_sd_oe_o  <= 1'b0;
            ack_o        <= 1'b1; // R15
            ack_fwd_o    <= 1'b1;
            rdata_o      <= write_q ? 16'h0000 : (wide_run_q ? sd_f : {8'h00, sd_f[7:0]});
          end
        end
        lib_pkg::LIB_ST_RECOV: begin
          if (cnt_q == 8'h00) begin
            st_q <= lib_pkg::LIB_ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          st_q <= lib_pkg::LIB_ST_IDLE;
        end
      endcase
    end
  end

  // Software configuration
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      com_q    <= `LIB_COM_RESET;
      irq_en_q <= `LIB_IRQ_EN_RESET; // R13
    end else if (reg_wr_i) begin
      if (reg_addr_i == `LIB_REG_COM) begin
        com_q <= reg_wdata_i; // R10
      end
      if (reg_addr_i == `LIB_REG_IRQ_EN) begin
        irq_en_q <= reg_wdata_i[15:0] & `LIB_IRQ_ROUTED; // R12 R13
      end
    end
  end

  // Sticky status; a new event beats a write-one clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blk_q    <= 1'b0;
      narrow_q <= 1'b0;
    end else begin
      blk_q    <= blk_set || (blk_q && !(sts_wr && reg_wdata_i[`LIB_ST_BLOCK_BIT]));
      narrow_q <= narrow_set || (narrow_q && !(sts_wr && reg_wdata_i[`LIB_ST_NARROW_BIT]));
    end
  end

  // Register read data, one cycle after the strobe only
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `LIB_REG_COM:    reg_rdata_o <= com_q;
        `LIB_REG_IRQ_EN: reg_rdata_o <= {16'h0000, irq_en_q};
        `LIB_REG_STATUS: reg_rdata_o <= {29'h0, narrow_q, blk_q, st_q != lib_pkg::LIB_ST_IDLE};
        default:         reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // Interrupts: each line passes alone, only when routed and enabled
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o  <= 16'h0000;
      busy_o <= 1'b0;
    end else begin
      irq_o  <= irq_f & irq_en_q & `LIB_IRQ_ROUTED; // R12 R13 R14
      busy_o <= (st_q != lib_pkg::LIB_ST_IDLE) || req_i;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  refresh_high_a: assert property (isa_refresh_n_o && !isa_tc_o) // R2
    else $error("refresh or terminal count active");
  dack_high_a: assert property (isa_dack_n_o == 7'h7f) // R3
    else $error("dma acknowledge active");
  tc_low_a: assert property ($rose(strobe) |-> !isa_tc_o [*4]) // R4
    else $error("terminal count rose");
  irq_gate_a: assert property ((irq_o & ~$past(irq_en_q & `LIB_IRQ_ROUTED)) == 16'h0000) // R12
    else $error("interrupt passed without enable");
  irq_reset_a: assert property ($rose(nrst_i) |-> irq_o == 16'h0000) // R13
    else $error("interrupt out of reset");
  wide_ok_a: assert property ($fell(isa_sbhe_n_o) |-> !$past(cs16_n_f) && !isa_memr_n_o == 1'b0) // R5
    else $error("wide cycle without width signal");
  logic_blk_a: assert property ((st_q == lib_pkg::LIB_ST_DEC) && !mem_q && (addr_q >= `LIB_LOGIC_LO)
                                && (addr_q <= `LIB_LOGIC_HI) |=> ack_o && !ack_fwd_o && !strobe) // R7
    else $error("on-board range forwarded");
  claim_blk_a: assert property ((st_q == lib_pkg::LIB_ST_DEC) && !mem_q && claim_q
                                |=> ack_o && !ack_fwd_o) // R6
    else $error("claimed address forwarded");
  mem_win_a: assert property ((!isa_memr_n_o || !isa_memw_n_o)
                              |-> (isa_sa_o >= `LIB_MEM_LO) && (isa_sa_o <= `LIB_MEM_HI)) // R11
    else $error("memory cycle outside window");
  cmd_width_a: assert property ($rose(strobe) |-> strobe [*5]) // R15
    else $error("command strobe too short");
  ack_pulse_a: assert property (ack_o |=> !ack_o) // R15
    else $error("answer longer than one cycle");
  fwd_ack_a: assert property ($fell(strobe) |-> ack_o && ack_fwd_o) // R15
    else $error("bus cycle ended without answer");

  io_read_c: cover property (!isa_ior_n_o ##[1:100] ack_o && ack_fwd_o);
  blocked_c: cover property (ack_o && !ack_fwd_o);
  wide_c: cover property ($fell(isa_sbhe_n_o) && !isa_iow_n_o);
endmodule
`default_nettype wire

// File: hw/lib_defines.svh
// Constants of the host to expansion-bus bridge: offsets, ranges, resets, timing
`ifndef LIB_DEFINES_SVH
`define LIB_DEFINES_SVH

// Register word offsets on the local register port
`define LIB_REG_COM        4'h0
`define LIB_REG_IRQ_EN     4'h4
`define LIB_REG_STATUS     4'h8

// Serial port config: one byte per port, select in [3:0], enable in [7]
`define LIB_COM_SEL_LSB    0
`define LIB_COM_EN_BIT     7
`define LIB_COM_RESET      32'h85_86_88_89

// Status fields
`define LIB_ST_BUSY_BIT    0
`define LIB_ST_BLOCK_BIT   1
`define LIB_ST_NARROW_BIT  2

// Interrupt lines passed to the host: 3..7, 9..12, 15
`define LIB_IRQ_ROUTED     16'h9ef8
`define LIB_IRQ_EN_RESET   16'h0000

// Ranges never forwarded
`define LIB_IDX_LO         20'h0002e
`define LIB_IDX_HI         20'h0002f
`define LIB_RT_LO          20'h00c00
`define LIB_RT_HI          20'h00c7f
`define LIB_LOGIC_LO       20'h00c80
`define LIB_LOGIC_HI       20'h00ccf
`define LIB_IO_TOP         20'h0ffff

// Memory window forwarded
`define LIB_MEM_LO         20'ha0000
`define LIB_MEM_HI         20'hb7fff

// Serial port base list
`define LIB_COM_B0         16'h0200
`define LIB_COM_B1         16'h0208
`define LIB_COM_B2         16'h0220
`define LIB_COM_B3         16'h0228
`define LIB_COM_B4         16'h0238
`define LIB_COM_B5         16'h02e8
`define LIB_COM_B6         16'h02f8
`define LIB_COM_B7         16'h0338
`define LIB_COM_B8         16'h03e8
`define LIB_COM_B9         16'h03f8

// Timing: clock period and bus phase lengths in ns
// Address phase must outlast the pin filter so the width line is current
`define LIB_CLK_NS         100
`define LIB_ADDR_NS        500
`define LIB_CMD_NS         500
`define LIB_RECOV_NS       200
`define LIB_RDY_MAX_NS     6400
`define LIB_ADDR_CYC       8'((`LIB_ADDR_NS + `LIB_CLK_NS - 1) / `LIB_CLK_NS)
`define LIB_CMD_CYC        8'((`LIB_CMD_NS + `LIB_CLK_NS - 1) / `LIB_CLK_NS)
`define LIB_RECOV_CYC      8'((`LIB_RECOV_NS + `LIB_CLK_NS - 1) / `LIB_CLK_NS)
`define LIB_RDY_MAX_CYC    8'(`LIB_RDY_MAX_NS / `LIB_CLK_NS)

`define LIB_RD_BLOCKED     16'hffff

`endif

// File: hw/lib_pkg.sv
// Types of the host to expansion-bus bridge
package lib_pkg;
  typedef enum logic [2:0] {
    LIB_ST_IDLE  = 3'b000,
    LIB_ST_DEC   = 3'b001,
    LIB_ST_ADDR  = 3'b010,
    LIB_ST_CMD   = 3'b011,
    LIB_ST_RECOV = 3'b100
  } lib_state_e;
  typedef logic [19:0] lib_addr_t;
endpackage

// File: hw/lib_dec_if.sv
// Interface between the bridge sequencer and its address decoder
`timescale 1ns/100ps
`default_nettype none
interface lib_dec_if;
  lib_pkg::lib_addr_t addr;
  logic               is_mem;
  logic               host_claim;
  logic [31:0]        com_cfg;
  logic [3:0]         com_hit;
  logic               fwd;
  modport seq (output addr, output is_mem, output host_claim, output com_cfg, input fwd, input com_hit);
  modport dec (input addr, input is_mem, input host_claim, input com_cfg, output fwd, output com_hit);
endinterface
`default_nettype wire

// File: hw/lib_decode.sv
// Address decoder: which host requests may reach the expansion bus
`timescale 1ns/100ps
`default_nettype none
`include "lib_defines.svh"
module lib_decode (
  lib_dec_if.dec d
);
  function automatic logic in_rng(input lib_pkg::lib_addr_t a, input lib_pkg::lib_addr_t lo,
                                  input lib_pkg::lib_addr_t hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [15:0] com_base(input logic [3:0] sel);
    case (sel)
      4'h0:    com_base = `LIB_COM_B0;
      4'h1:    com_base = `LIB_COM_B1;
      4'h2:    com_base = `LIB_COM_B2;
      4'h3:    com_base = `LIB_COM_B3;
      4'h4:    com_base = `LIB_COM_B4;
      4'h5:    com_base = `LIB_COM_B5;
      4'h6:    com_base = `LIB_COM_B6;
      4'h7:    com_base = `LIB_COM_B7;
      4'h8:    com_base = `LIB_COM_B8;
      default: com_base = `LIB_COM_B9; // R10
    endcase
  endfunction

  logic io_blk;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_com
      logic [3:0]  sel;
      logic [15:0] base;
      assign sel       = d.com_cfg[8*i+`LIB_COM_SEL_LSB +: 4];
      assign base      = com_base(sel);
      // Whole 8-byte block claimed while enabled
      assign d.com_hit[i] = d.com_cfg[8*i+`LIB_COM_EN_BIT] && (d.addr[19:3] == {4'h0, base[15:3]}); // R9 R10
    end
  endgenerate

  assign io_blk = d.host_claim // R6
               || in_rng(d.addr, `LIB_IDX_LO, `LIB_IDX_HI) || in_rng(d.addr, `LIB_RT_LO, `LIB_RT_HI) // R8
               || in_rng(d.addr, `LIB_LOGIC_LO, `LIB_LOGIC_HI) // R7
               || (d.addr > `LIB_IO_TOP) || (|d.com_hit);
  assign d.fwd = d.is_mem ? in_rng(d.addr, `LIB_MEM_LO, `LIB_MEM_HI) : !io_blk; // R11
endmodule
`default_nettype wire

// File: sim/lib_isa_model.sv
// Behavioural expansion-bus module answering the bridge's cycles
`timescale 1ns/100ps
`default_nettype none
module lib_isa_model (
  input  wire logic        clk_i,
  input  wire logic [19:0] sa_i,
  input  wire logic        ior_n_i,
  input  wire logic        iow_n_i,
  input  wire logic        memr_n_i,
  input  wire logic        memw_n_i,
  input  wire logic [15:0] sd_i,
  input  wire logic [7:0]  wait_i,
  output var  logic [15:0] sd_o,
  output logic             iocs16_n_o,
  output logic             iochrdy_o,
  output var  logic [15:0] wdata_o,
  output var  int          cmds_o
);
  // Slave only: no ownership request, drives no interrupt line
  logic       rd;
  logic       wr;
  logic       cmd_q;
  logic [7:0] wcnt;
  logic [15:0] idle_q;
  assign rd = !ior_n_i || !memr_n_i;
  assign wr = !iow_n_i || !memw_n_i;
  // Only I/O 0x300-0x30f is a 16-bit module
  assign iocs16_n_o = !(sa_i[19:4] == 16'h0030);
  // Ready pulled low at once, else the bridge's input filter would miss it
  assign iochrdy_o = !((rd || wr) && wait_i != 8'h00 && (!cmd_q || wcnt != 8'h00));
  // Read data follow the strobe at once, as a real module's decoder would
  assign sd_o = rd ? (sa_i[15:0] ^ 16'h5a3c) : idle_q;
  initial begin
    cmds_o = 0;
    cmd_q = 1'b0;
    wcnt = 8'h00;
    idle_q = 16'h0000;
  end
  always @(posedge clk_i) begin
    cmd_q <= rd || wr;
    if ((rd || wr) && !cmd_q) begin
      cmds_o <= cmds_o + 1;
      wcnt <= wait_i;
    end else if (wcnt != 8'h00) begin
      wcnt <= wcnt - 8'h01;
    end
    if (wr) wdata_o <= sd_i;
    // Released bus shows a pattern that changes every cycle
    idle_q <= ~idle_q;
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench of the bridge against a rule model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        ref_clk_i = 1'b0, nrst_i, reg_wr_i, reg_rd_i, req_i, req_mem_i, req_write_i, req_wide_i;
  logic        host_claim_i, ack_o, ack_fwd_o, busy_o, isa_ior_n_o, isa_iow_n_o, isa_memr_n_o, isa_memw_n_o;
  logic        isa_sd_oe_o, isa_iocs16_n_i, isa_iochrdy_i, isa_refresh_n_o, isa_tc_o, isa_ale_o, isa_sbhe_n_o;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, cfg;
  logic [19:0] req_addr_i, isa_sa_o;
  logic [15:0] req_wdata_i, rdata_o, isa_sd_i, isa_sd_o, pd, wseen, isa_irq_i, irq_o, en, ir;
  logic [6:0]  isa_dack_n_o;
  logic [7:0]  wait_cyc;
  logic        blk, nar;
  int          cmds, failures, total_checks, i, ales, wides;
  logic [20:0] tab [16] = '{21'h0002e, 21'h0002f, 21'h00c00, 21'h00c7f, 21'h00c80, 21'h00ccf, 21'h003f8,
                            21'h002ff, 21'h02ef0, 21'h10000, 21'h19ffff, 21'h1b8000, 21'h0001f, 21'h00cd0,
                            21'h1a0000, 21'h1b7fff};
  assign isa_sd_i = isa_sd_oe_o ? isa_sd_o : pd;
  lib_bridge u_lib_bridge (.ref_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .req_i, .req_mem_i, .req_write_i, .req_wide_i, .req_addr_i, .req_wdata_i, .host_claim_i, .ack_o, .ack_fwd_o,
    .rdata_o, .busy_o, .isa_sa_o, .isa_ale_o, .isa_sbhe_n_o, .isa_ior_n_o, .isa_iow_n_o, .isa_memr_n_o,
    .isa_memw_n_o, .isa_sd_i, .isa_sd_o, .isa_sd_oe_o, .isa_iocs16_n_i, .isa_iochrdy_i, .isa_irq_i, .irq_o,
    .isa_refresh_n_o, .isa_dack_n_o, .isa_tc_o);
  lib_isa_model u_lib_isa_model (.clk_i(ref_clk_i), .sa_i(isa_sa_o), .ior_n_i(isa_ior_n_o), .iow_n_i(isa_iow_n_o),
    .memr_n_i(isa_memr_n_o), .memw_n_i(isa_memw_n_o), .sd_i(isa_sd_i), .wait_i(wait_cyc), .sd_o(pd),
    .iocs16_n_o(isa_iocs16_n_i), .iochrdy_o(isa_iochrdy_i), .wdata_o(wseen), .cmds_o(cmds));
  always #50 ref_clk_i = ~ref_clk_i;
  // Address strobes and wide command cycles seen on the expansion bus
  always @(posedge ref_clk_i) begin
    if (isa_ale_o === 1'b1) ales <= ales + 1;
    if (isa_sbhe_n_o === 1'b0 && (isa_ior_n_o === 1'b0 || isa_iow_n_o === 1'b0)) wides <= wides + 1;
  end

  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(reg_rdata_o, e, "register read");
  endtask
  function automatic logic [15:0] cbase(input logic [3:0] s);
    logic [15:0] t [10] = '{16'h0200, 16'h0208, 16'h0220, 16'h0228, 16'h0238, 16'h02e8, 16'h02f8, 16'h0338,
                            16'h03e8, 16'h03f8};
    return s > 4'h9 ? 16'h03f8 : t[s];
  endfunction
  function automatic bit fwd(input bit m, input logic [19:0] a, input bit cl);
    if (m) return a >= 20'ha0000 && a <= 20'hb7fff;
    if (cl || a > 20'h0ffff) return 1'b0;
    if (a == 20'h0002e || a == 20'h0002f || (a >= 20'h00c00 && a <= 20'h00ccf)) return 1'b0;
    for (int k = 0; k < 4; k++)
      if (cfg[k*8+7] && a[15:3] == 13'(cbase(cfg[k*8+:4]) >> 3)) return 1'b0;
    return 1'b1;
  endfunction
  task automatic req(input bit m, input bit w, input bit wd, input logic [19:0] a, input bit cl, input bit dup);
    int n0, k, a0, w0;
    logic [15:0] d;
    bit f, n16;
    f = fwd(m, a, cl);
    n16 = wd && !m && a[19:4] == 16'h0030;
    n0 = cmds;
    a0 = ales;
    w0 = wides;
    d = 16'($urandom);
    @(posedge ref_clk_i);
    req_i <= 1'b1; req_mem_i <= m; req_write_i <= w; req_wide_i <= wd;
    req_addr_i <= a; req_wdata_i <= d; host_claim_i <= cl; wait_cyc <= 8'($urandom % 20);
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    if (dup) begin
      @(posedge ref_clk_i);
      req_i <= 1'b1;
      @(posedge ref_clk_i);
      req_i <= 1'b0;
    end
    for (k = 0; k < 300 && ack_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk(ack_o, 1'b1, "answer");
    chk(ack_fwd_o, f, "forward decision");
    chk(rdata_o, !f ? 16'hffff : w ? 16'h0000 : n16 ? a[15:0] ^ 16'h5a3c : {8'h00, a[7:0] ^ 8'h3c}, "data");
    if (f && w) chk(n16 ? wseen : {8'h00, wseen[7:0]}, n16 ? d : {8'h00, d[7:0]}, "write data");
    blk |= !f;
    nar |= f && wd && !n16;
    for (k = 0; k < 20 && busy_o !== 1'b0; k++) @(negedge ref_clk_i);
    if (dup) repeat (3) @(negedge ref_clk_i);
    chk(busy_o, 1'b0, "idle");
    chk(cmds - n0, f, "bus cycle count");
    chk(ales - a0, f, "address latch pulses");
    chk(wides != w0, n16, "wide command");
  endtask

  initial begin
    #2_000_000;
    failures++;
    results;
  end
  initial begin
    {nrst_i, reg_wr_i, reg_rd_i, req_i, req_mem_i, req_write_i, req_wide_i, host_claim_i} = '0;
    {reg_addr_i, reg_wdata_i, req_addr_i, req_wdata_i, isa_irq_i, wait_cyc, blk, nar} = '0;
    cfg = 32'h85868889;
    void'($urandom(50571));
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk({isa_refresh_n_o, isa_dack_n_o, isa_tc_o}, 9'h1fe, "fixed outputs");
    rreg(4'h0, cfg);
    rreg(4'h4, 32'h0);
    rreg(4'h8, 32'h0);
    rreg(4'hc, 32'h0);
    $display("test reset done");
    for (i = 0; i < 16; i++) req(tab[i][20], i[0], 1'b0, tab[i][19:0], 1'b0, 1'b0);
    req(1'b0, 1'b0, 1'b0, 20'h00300, 1'b1, 1'b0);
    rreg(4'h8, {29'h0, nar, blk, 1'b0});
    wreg(4'h8, 32'h6);
    rreg(4'h8, 32'h0);
    {blk, nar} = 2'b00;
    $display("test decode done");
    req(1'b0, 1'b0, 1'b1, 20'h00300, 1'b0, 1'b1);
    req(1'b0, 1'b1, 1'b1, 20'h0030e, 1'b0, 1'b0);
    req(1'b0, 1'b0, 1'b1, 20'h0001f, 1'b0, 1'b0);
    rreg(4'h8, {29'h0, nar, blk, 1'b0});
    $display("test width done");
    for (i = 0; i < 4; i++) begin
      cfg[7:0] = i == 0 ? 8'h00 : i == 1 ? 8'h80 : i == 2 ? 8'h8f : 8'h84;
      wreg(4'h0, cfg);
      rreg(4'h0, cfg);
      req(1'b0, 1'b0, 1'b0, 20'h003f8, 1'b0, 1'b0);
      req(1'b0, 1'b1, 1'b0, 20'h00207, 1'b0, 1'b0);
      req(1'b0, 1'b0, 1'b0, 20'h00238, 1'b0, 1'b0);
    end
    $display("test serial map done");
    for (i = 0; i < 6; i++) begin
      en = i == 0 ? 16'h0000 : i == 1 ? 16'hffff : 16'($urandom);
      ir = i < 2 ? 16'hffff : 16'($urandom);
      wreg(4'h4, {16'h0, en});
      @(posedge ref_clk_i);
      isa_irq_i <= ir;
      repeat (8) @(negedge ref_clk_i);
      chk(irq_o, ir & en & 16'h9ef8, "interrupt gate");
      rreg(4'h4, {16'h0, en & 16'h9ef8});
    end
    $display("test interrupts done");
    chk({isa_refresh_n_o, isa_dack_n_o, isa_tc_o}, 9'h1fe, "fixed outputs");
    results;
  end
endmodule
`default_nettype wire
